// ==== src/smst_sync_tx.sv ====
// clocked master serial transmitter with apb register file
// assumes i_clk_sys at 100 MHz; the clock pin input is asynchronous and synchronised here, the data pin input is unused
//
// What this block does
// R01: half-duplex: transmit and receive never together
// R02: clocked mode entered by clocked_mode_select bit
// R03: serial_port_enable assigns clock and data pins
// R04: clock_source_master drives shift clock out
// R05: shift register reloads only after last bit
// R06: one-cycle load empties buffer, sets flag
// R07: empty flag cleared only by buffer write
// R08: irq request when flag and enable set
// R09: shifter_empty_flag read-only, polled, no irq
// R10: transmit_enable enables; waits for buffered data
// R11: bit presented on rise, stable at fall
// R12: baud generator reset while all enables clear
// R13: buffer written before enable still transmits
// R14: empty shifter takes write at once
// R15: clearing transmit_enable aborts, releases both pins
// R16: receive enable aborts, releases data only
// R17: single receive done clears enable, resumes
// R18: nine-bit mode sends ninth_transmit_bit
// R19: ninth bit captured at buffer load
// R20: software sets up in documented order
// R21: least significant bit first, ninth last
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/10ps

module smst_sync_tx
  import smst_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // clock, reset, enable
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // shift clock and data pins
  input wire logic i_ck_in,
  input wire logic i_dt_in,
  output smst_pins_s o_pins,
  // transmit interrupt request
  output logic o_tx_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // register decode

  function automatic logic smst_mapped(input logic [ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    if (a[ADDR_W-1:10] == '0) begin
      unique case (a[9:2])
        IDX_INTERRUPT_CONTROL, IDX_PERIPHERAL_IRQ_FLAGS,
        IDX_RECEIVE_STATUS_CONTROL, IDX_TRANSMIT_BUFFER,
        IDX_PERIPHERAL_IRQ_ENABLES, IDX_TRANSMIT_STATUS_CONTROL,
        IDX_BAUD_DIVISOR: hit = 1'b1;
        default: hit = 1'b0;
      endcase
    end
    return hit;
  endfunction

  function automatic logic smst_wr(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    return a[ADDR_W-1:10] == '0 && a[9:2] == idx;
  endfunction

  logic acc_w;
  logic wr_w;
  logic [7:0] wd_w;
  assign acc_w = i_psel && i_penable && i_ce;
  assign wr_w = acc_w && i_pwrite;
  assign wd_w = i_pwdata[7:0];
  assign o_pready = i_ce;
  assign o_pslverr = i_psel && i_penable && !smst_mapped(i_paddr);

  logic wr_interrupt_control_w;
  logic wr_pir_w;
  logic wr_rxsc_w;
  logic wr_buf_w;
  logic wr_pie_w;
  logic wr_txsc_w;
  logic wr_baud_w;
  assign wr_interrupt_control_w = wr_w && smst_wr(i_paddr, IDX_INTERRUPT_CONTROL);
  assign wr_pir_w = wr_w && smst_wr(i_paddr, IDX_PERIPHERAL_IRQ_FLAGS);
  assign wr_rxsc_w = wr_w && smst_wr(i_paddr, IDX_RECEIVE_STATUS_CONTROL);
  assign wr_buf_w = wr_w && smst_wr(i_paddr, IDX_TRANSMIT_BUFFER);
  assign wr_pie_w = wr_w && smst_wr(i_paddr, IDX_PERIPHERAL_IRQ_ENABLES);
  assign wr_txsc_w = wr_w && smst_wr(i_paddr, IDX_TRANSMIT_STATUS_CONTROL);
  assign wr_baud_w = wr_w && smst_wr(i_paddr, IDX_BAUD_DIVISOR);

  ////////////////////////////////////////////////////////////////////////////
  // software registers

  logic [7:0] interrupt_control_reg;
  logic [7:0] pir_keep_reg;
  logic [7:0] pie_reg;
  logic [7:0] txsc_reg;
  logic [7:0] rxsc_reg;
  logic [7:0] baud_div_reg;
  logic single_receive_enable_clr_w;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      interrupt_control_reg <= RST_INTERRUPT_CONTROL;
      pir_keep_reg <= RST_PERIPHERAL_IRQ_FLAGS;
      pie_reg <= RST_PERIPHERAL_IRQ_ENABLES;
      txsc_reg <= RST_TRANSMIT_STATUS_CONTROL;
      baud_div_reg <= RST_BAUD_DIVISOR;
    end else if (i_ce) begin
      if (wr_interrupt_control_w) begin
        interrupt_control_reg <= wd_w;
      end
      if (wr_pir_w) begin
        pir_keep_reg <= wd_w & PIR_STORE_MASK;
      end
      if (wr_pie_w) begin
        pie_reg <= wd_w;
      end
      if (wr_txsc_w) begin
        txsc_reg <= wd_w & ~8'h0a; // status bit and bit 3 not stored
      end
      if (wr_baud_w) begin
        baud_div_reg <= wd_w;
      end
    end
  end

  // single-word receive end clears its enable; a same-cycle write wins
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      rxsc_reg <= RST_RECEIVE_STATUS_CONTROL;
    end else if (i_ce) begin
      if (wr_rxsc_w) begin
        rxsc_reg <= wd_w & 8'hf8;
      end else if (single_receive_enable_clr_w) begin
        rxsc_reg[RXSC_SINGLE_RECEIVE] <= 1'b0; // [R17]
      end
    end
  end

  logic clock_source_master_w;
  logic tx9_w;
  logic transmit_enable_w;
  logic rx_en_w;
  logic port_on_w;
  logic rx_active_w;
  assign clock_source_master_w = txsc_reg[TXSC_CLOCK_SOURCE_MASTER];
  assign tx9_w = txsc_reg[TXSC_NINE_BIT_SELECT];
  assign transmit_enable_w = txsc_reg[TXSC_TRANSMIT_ENABLE];
  assign rx_en_w = rxsc_reg[RXSC_SINGLE_RECEIVE] || rxsc_reg[RXSC_CONTINUOUS_RECEIVE];
  // clocked mode and port enable together claim the pins
  assign port_on_w = txsc_reg[TXSC_CLOCKED_MODE] && rxsc_reg[RXSC_SERIAL_PORT_ENABLE]; // [R02] [R03]
  assign rx_active_w = port_on_w && rx_en_w;

  ////////////////////////////////////////////////////////////////////////////
  // clock pin synchroniser and external clock edges

  logic ck_s1_reg;
  logic ck_s2_reg;
  logic ck_s3_reg;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      ck_s1_reg <= 1'b0;
      ck_s2_reg <= 1'b0;
      ck_s3_reg <= 1'b0;
    end else if (i_ce) begin
      ck_s1_reg <= i_ck_in;
      ck_s2_reg <= ck_s1_reg;
      ck_s3_reg <= ck_s2_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // baud generator and shift clock

  logic [7:0] baud_cnt_reg;
  logic ck_reg;
  logic tsr_full_reg;
  logic bg_run_w;
  logic tick_w;
  logic tx_shift_w;
  logic busy_w;
  logic rise_w;
  logic fall_w;

  assign bg_run_w = transmit_enable_w || rx_en_w;
  assign tick_w = bg_run_w && baud_cnt_reg == baud_div_reg;
  assign tx_shift_w = port_on_w && transmit_enable_w && tsr_full_reg && !rx_active_w; // [R01]
  assign busy_w = tx_shift_w || rx_active_w;
  assign rise_w = clock_source_master_w ? (tick_w && busy_w && !ck_reg) : (ck_s2_reg && !ck_s3_reg);
  assign fall_w = clock_source_master_w ? (tick_w && busy_w && ck_reg) : (!ck_s2_reg && ck_s3_reg);

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      baud_cnt_reg <= 8'h00;
    end else if (i_ce) begin
      if (!bg_run_w || tick_w) begin
        baud_cnt_reg <= 8'h00; // [R12]
      end else begin
        baud_cnt_reg <= baud_cnt_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      ck_reg <= 1'b0;
    end else if (i_ce) begin
      if (!bg_run_w || !busy_w) begin
        ck_reg <= 1'b0; // [R12] [R15]
      end else if (clock_source_master_w && tick_w) begin
        ck_reg <= !ck_reg; // [R04]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit buffer and empty flag

  logic [7:0] txbuf_reg;
  logic buf_full_reg;
  logic transmit_buffer_empty_flag_reg;
  logic load_w;

  assign load_w = !tsr_full_reg && buf_full_reg && transmit_enable_w; // [R05] [R10] [R13] [R14]

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      txbuf_reg <= RST_TRANSMIT_BUFFER;
      buf_full_reg <= 1'b0;
    end else if (i_ce) begin
      if (wr_buf_w) begin
        txbuf_reg <= wd_w;
        buf_full_reg <= 1'b1;
      end else if (load_w) begin
        buf_full_reg <= 1'b0; // [R06]
      end
    end
  end

  // a write in the load cycle refills the buffer, so the flag stays clear
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      transmit_buffer_empty_flag_reg <= 1'b0;
    end else if (i_ce) begin
      if (wr_buf_w) begin
        transmit_buffer_empty_flag_reg <= 1'b0; // [R07]
      end else if (load_w) begin
        transmit_buffer_empty_flag_reg <= 1'b1; // [R06] [R07]
      end
    end
  end

  assign o_tx_irq = transmit_buffer_empty_flag_reg && pie_reg[ENA_TRANSMIT_IRQ]; // [R08]

  ////////////////////////////////////////////////////////////////////////////
  // transmit shift register

  logic [8:0] tsr_reg;
  logic [3:0] bits_left_reg;
  logic dt_reg;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      tsr_reg <= 9'h000;
      tsr_full_reg <= 1'b0;
      bits_left_reg <= 4'h0;
      dt_reg <= 1'b0;
    end else if (i_ce) begin
      if (!transmit_enable_w) begin
        tsr_full_reg <= 1'b0; // [R15]
        bits_left_reg <= 4'h0;
        dt_reg <= 1'b0;
      end else if (load_w) begin
        tsr_reg <= {tx9_w && txsc_reg[TXSC_NINTH_BIT], txbuf_reg}; // [R18] [R19]
        tsr_full_reg <= 1'b1;
        bits_left_reg <= tx9_w ? WORD_BITS_9 : WORD_BITS_8;
      end else if (tx_shift_w && rise_w) begin
        dt_reg <= tsr_reg[0]; // [R11] [R21]
        tsr_reg <= {1'b0, tsr_reg[8:1]};
      end else if (tx_shift_w && fall_w) begin
        bits_left_reg <= bits_left_reg - 4'h1;
        if (bits_left_reg == 4'h1) begin
          tsr_full_reg <= 1'b0; // [R05]
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive bit counting, only to end a single-word receive

  logic [3:0] rx_cnt_reg;
  logic [3:0] rx_len_w;
  assign rx_len_w = rxsc_reg[RXSC_NINE_BIT_RECEIVE] ? WORD_BITS_9 : WORD_BITS_8;
  assign single_receive_enable_clr_w = rx_active_w && fall_w && !rxsc_reg[RXSC_CONTINUOUS_RECEIVE]
    && rx_cnt_reg == rx_len_w - 4'h1;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      rx_cnt_reg <= 4'h0;
    end else if (i_ce) begin
      if (!rx_active_w || single_receive_enable_clr_w) begin
        rx_cnt_reg <= 4'h0;
      end else if (fall_w) begin
        rx_cnt_reg <= rx_cnt_reg + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins

  always_comb begin
    o_pins.ck_out = ck_reg;
    o_pins.ck_oe = port_on_w && clock_source_master_w && bg_run_w; // [R04] [R15] [R16]
    o_pins.dt_out = dt_reg;
    o_pins.dt_oe = port_on_w && transmit_enable_w && !rx_active_w; // [R01] [R15] [R16] [R17]
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, captured in the setup phase

  logic [7:0] rd_w;
  always_comb begin
    rd_w = 8'h00;
    if (i_paddr[ADDR_W-1:10] == '0) begin
      unique case (i_paddr[9:2])
        IDX_INTERRUPT_CONTROL: rd_w = interrupt_control_reg;
        IDX_PERIPHERAL_IRQ_FLAGS: begin
          rd_w = pir_keep_reg;
          rd_w[FLAG_TRANSMIT_BUFFER_EMPTY] = transmit_buffer_empty_flag_reg;
        end
        IDX_RECEIVE_STATUS_CONTROL: rd_w = rxsc_reg;
        IDX_TRANSMIT_BUFFER: rd_w = txbuf_reg;
        IDX_PERIPHERAL_IRQ_ENABLES: rd_w = pie_reg;
        IDX_TRANSMIT_STATUS_CONTROL: begin
          rd_w = txsc_reg;
          rd_w[TXSC_SHIFTER_EMPTY] = !tsr_full_reg; // [R09]
        end
        IDX_BAUD_DIVISOR: rd_w = baud_div_reg;
        default: rd_w = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_prdata <= 32'h0000_0000;
    end else if (i_ce && i_psel && !i_penable) begin
      o_prdata <= {24'h00_0000, rd_w};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  sequence s_tx_rise;
    i_ce && tx_shift_w && rise_w;
  endsequence

  sequence s_single_done;
    i_ce && single_receive_enable_clr_w && !wr_rxsc_w && !wr_txsc_w;
  endsequence

  a_half_duplex: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [R01]
    !(o_pins.dt_oe && rx_active_w))
    else $error("data driven while receiving");

  a_pins_claim: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [R02]
    (o_pins.ck_oe || o_pins.dt_oe) |-> txsc_reg[TXSC_CLOCKED_MODE]
      && rxsc_reg[RXSC_SERIAL_PORT_ENABLE])
    else $error("pin driven outside clocked port mode");

  a_master_clock: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [R04]
    (port_on_w && clock_source_master_w && transmit_enable_w) |-> o_pins.ck_oe)
    else $error("master clock not driven");

  a_load_prompt: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [R05]
    (i_ce && tx_shift_w && fall_w && bits_left_reg == 4'h1 && buf_full_reg
      && !wr_txsc_w) |=> (!i_ce || load_w) ##1 (!i_ce || tsr_full_reg))
    else $error("waiting word not loaded after last bit");

  a_flag_on_load: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [R06]
    (i_ce && load_w && !wr_buf_w) |=> transmit_buffer_empty_flag_reg && !buf_full_reg)
    else $error("empty flag not set by load");

  a_flag_sticks: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [R07]
    (transmit_buffer_empty_flag_reg && !wr_buf_w) |=> transmit_buffer_empty_flag_reg)
    else $error("empty flag cleared without buffer write");

  a_irq_gate: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [R08]
    o_tx_irq |-> transmit_buffer_empty_flag_reg && pie_reg[ENA_TRANSMIT_IRQ])
    else $error("irq without flag and enable");

  a_shifter_read: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [R09]
    (i_ce && i_psel && !i_penable
      && smst_wr(i_paddr, IDX_TRANSMIT_STATUS_CONTROL))
      |=> o_prdata[TXSC_SHIFTER_EMPTY] == !$past(tsr_full_reg))
    else $error("shifter empty bit wrong");

  a_baud_held: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [R12]
    (i_ce && !bg_run_w) |=> baud_cnt_reg == 8'h00 && !ck_reg)
    else $error("baud generator not held");

  a_abort_reset: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [R15]
    (i_ce && !transmit_enable_w && !wr_txsc_w) |=> !tsr_full_reg && !o_pins.dt_oe)
    else $error("transmitter not reset by enable clear");

  a_rx_keeps_ck: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [R16]
    (rx_active_w && clock_source_master_w) |-> o_pins.ck_oe && !o_pins.dt_oe)
    else $error("receive abort pins wrong");

  a_rx_resume: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [R17]
    s_single_done |=> !rxsc_reg[RXSC_SINGLE_RECEIVE]
      && (o_pins.dt_oe || !transmit_enable_w || rxsc_reg[RXSC_CONTINUOUS_RECEIVE]))
    else $error("single receive did not hand back");

  a_ninth_load: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [R19]
    (i_ce && load_w && transmit_enable_w) |=> tsr_reg[8] == $past(tx9_w && txsc_reg[TXSC_NINTH_BIT]))
    else $error("ninth bit not captured at load");

  a_lsb_first: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [R11]
    s_tx_rise |=> dt_reg == $past(tsr_reg[0]) && tsr_reg[8] == 1'b0)
    else $error("bit order wrong");

endmodule

// ==== pkg/smst_pkg.sv ====
// package of the clocked master serial transmitter: register map, fields, resets
// assumes a 32-bit apb slave; each register takes one word at four times its index
package smst_pkg;

  // register indices (byte address is four times the index)
  localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0b;
  localparam logic [7:0] IDX_PERIPHERAL_IRQ_FLAGS = 8'h0c;
  localparam logic [7:0] IDX_RECEIVE_STATUS_CONTROL = 8'h18;
  localparam logic [7:0] IDX_TRANSMIT_BUFFER = 8'h19;
  localparam logic [7:0] IDX_PERIPHERAL_IRQ_ENABLES = 8'h8c;
  localparam logic [7:0] IDX_TRANSMIT_STATUS_CONTROL = 8'h98;
  localparam logic [7:0] IDX_BAUD_DIVISOR = 8'h99;

  // transmit_status_control fields
  localparam int TXSC_CLOCK_SOURCE_MASTER = 7;
  localparam int TXSC_NINE_BIT_SELECT = 6;
  localparam int TXSC_TRANSMIT_ENABLE = 5;
  localparam int TXSC_CLOCKED_MODE = 4;
  localparam int TXSC_HIGH_SPEED = 2;
  localparam int TXSC_SHIFTER_EMPTY = 1;
  localparam int TXSC_NINTH_BIT = 0;

  // receive_status_control fields
  localparam int RXSC_SERIAL_PORT_ENABLE = 7;
  localparam int RXSC_NINE_BIT_RECEIVE = 6;
  localparam int RXSC_SINGLE_RECEIVE = 5;
  localparam int RXSC_CONTINUOUS_RECEIVE = 4;
  localparam int RXSC_ADDRESS_DETECT = 3;

  // flag and enable positions
  localparam int FLAG_TRANSMIT_BUFFER_EMPTY = 4;
  localparam int ENA_TRANSMIT_IRQ = 4;
  localparam logic [7:0] PIR_STORE_MASK = 8'h6f;

  // reset values
  localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h00;
  localparam logic [7:0] RST_PERIPHERAL_IRQ_FLAGS = 8'h00;
  localparam logic [7:0] RST_RECEIVE_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] RST_TRANSMIT_BUFFER = 8'h00;
  localparam logic [7:0] RST_PERIPHERAL_IRQ_ENABLES = 8'h00;
  localparam logic [7:0] RST_TRANSMIT_STATUS_CONTROL = 8'h02;
  localparam logic [7:0] RST_BAUD_DIVISOR = 8'h00;

  // word lengths in shift clock periods
  localparam logic [3:0] WORD_BITS_8 = 4'h8;
  localparam logic [3:0] WORD_BITS_9 = 4'h9;

  // two-way shift clock and data pins, output side
  typedef struct packed {
    logic ck_out;
    logic ck_oe;
    logic dt_out;
    logic dt_oe;
  } smst_pins_s;

endpackage

// ==== sim/smst_slave_model.sv ====
// clocked serial slave on the shift clock and data lines
// assumes the master drives data; the clock comes from either side; samples on falls
`timescale 1ns/10ps

module smst_slave_model
  import smst_pkg::*;
(
  // system side
  input wire logic i_clk_sys,
  input wire logic i_clr,
  // external shift clock: drive the line, then let it toggle
  input wire logic i_ext_en,
  input wire logic i_ext_run,
  // pins from the master
  input wire smst_pins_s i_pins,
  // resolved lines and capture
  output logic o_ck_line,
  output logic o_dt_line,
  output logic [31:0] o_shift,
  output int o_count
);
  logic ck_q = 1'b0;
  logic oe_q = 1'b0;
  logic ck_last = 1'b0;
  logic dt_last = 1'b0;
  logic ext_ck = 1'b0;

  // own 125 ns shift clock, standing low outside frames
  always #62.5 ext_ck = i_ext_run ? ~ext_ck : 1'b0;

  // released lines show the inverse of their last driven level; the clock line shows ext_ck instead while i_ext_en is set
  assign o_ck_line = i_pins.ck_oe ? i_pins.ck_out : (i_ext_en ? ext_ck : ~ck_last);
  assign o_dt_line = i_pins.dt_oe ? i_pins.dt_out : ~dt_last;

  // sample only on falls made by whoever clocks the link, never on a release
  always_ff @(posedge i_clk_sys) begin
    ck_q <= o_ck_line;
    oe_q <= i_pins.ck_oe;
    if (i_pins.ck_oe) begin
      ck_last <= i_pins.ck_out;
    end
    if (i_pins.dt_oe) begin
      dt_last <= i_pins.dt_out;
    end
    if (i_clr) begin
      o_shift <= '0;
      o_count <= 0;
    end else if (ck_q && !o_ck_line && (i_ext_run || (i_pins.ck_oe && oe_q))) begin
      o_shift <= {o_dt_line, o_shift[31:1]};
      o_count <= o_count + 1;
    end
  end
endmodule

// ==== sim/tb_top.sv ====
// self-checking bench of the clocked master serial transmitter
// assumes a slave model on the pins and a zero-wait apb slave
`timescale 1ns/10ps

module tb_top;
  import smst_pkg::*;

  typedef struct packed {
    logic [7:0] data;
    logic nine;
    logic ninth;
    logic [7:0] div;
  } smst_row_s;

  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [11:0] i_paddr = '0;
  logic [31:0] i_pwdata = '0;
  logic [31:0] o_prdata;
  logic o_pready, o_pslverr, o_tx_irq, ck_line, dt_line;
  logic clr = 1'b0;
  logic i_ce = 1'b1;
  logic ext_en = 1'b0;
  logic ext_run = 1'b0;
  smst_pins_s o_pins;
  logic [31:0] shift, rd, exp_w;
  logic err;
  int count, n;
  int n_fail = 0;
  int cmp_count = 0;
  smst_row_s rows [4] = '{'{8'ha5, 1'b0, 1'b0, 8'h00}, '{8'h3c, 1'b1, 1'b1, 8'h01},
    '{8'hff, 1'b1, 1'b0, 8'h02}, '{8'h01, 1'b0, 1'b0, 8'h03}};
  logic [7:0] ridx [7] = '{IDX_INTERRUPT_CONTROL, IDX_PERIPHERAL_IRQ_FLAGS,
    IDX_RECEIVE_STATUS_CONTROL, IDX_TRANSMIT_BUFFER, IDX_PERIPHERAL_IRQ_ENABLES,
    IDX_TRANSMIT_STATUS_CONTROL, IDX_BAUD_DIVISOR};
  logic [7:0] rexp [7] = '{RST_INTERRUPT_CONTROL, RST_PERIPHERAL_IRQ_FLAGS,
    RST_RECEIVE_STATUS_CONTROL, RST_TRANSMIT_BUFFER, RST_PERIPHERAL_IRQ_ENABLES,
    RST_TRANSMIT_STATUS_CONTROL, RST_BAUD_DIVISOR};

  always #5 i_clk_sys = ~i_clk_sys;

  smst_sync_tx smst_sync_tx_i (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_ce(i_ce),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_ck_in(ck_line), .i_dt_in(dt_line), .o_pins(o_pins), .o_tx_irq(o_tx_irq)
  );

  smst_slave_model smst_slave_model_i (
    .i_clk_sys(i_clk_sys), .i_clr(clr), .i_ext_en(ext_en), .i_ext_run(ext_run),
    .i_pins(o_pins), .o_ck_line(ck_line),
    .o_dt_line(dt_line), .o_shift(shift), .o_count(count)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      n_fail++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= {2'b00, idx, 2'b00};
    i_pwdata <= {24'h0, wd};
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    do @(posedge i_clk_sys); while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk_sys);
  endtask

  task automatic bits(input int want);
    int k;
    k = 0;
    while (count < want && k < 4000) begin
      @(posedge i_clk_sys);
      k++;
    end
    chk(count, want);
  endtask

  task automatic clear_model();
    clr <= 1'b1;
    @(posedge i_clk_sys);
    clr <= 1'b0;
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #300us;
    n_fail++;
    close_out();
  end

  initial begin
    repeat (2) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    @(posedge i_clk_sys);
    chk(o_pins, 4'h0);
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, ridx[i], 8'h00);
      chk(rd, {24'h0, rexp[i]});
    end
    apb(1'b0, 8'h01, 8'h00);
    chk({err, rd[30:0]}, 32'h80000000);
    $display("reset and map done");
    // word rows: buffer loaded first, then enable
    apb(1'b1, IDX_RECEIVE_STATUS_CONTROL, 8'h80);
    for (int i = 0; i < 4; i++) begin
      n = rows[i].nine ? 9 : 8;
      exp_w = {23'h0, rows[i].nine & rows[i].ninth, rows[i].data};
      apb(1'b1, IDX_BAUD_DIVISOR, rows[i].div);
      apb(1'b1, IDX_TRANSMIT_STATUS_CONTROL, {1'b1, rows[i].nine, 5'h08, rows[i].ninth});
      apb(1'b1, IDX_TRANSMIT_BUFFER, rows[i].data);
      clear_model();
      apb(1'b1, IDX_TRANSMIT_STATUS_CONTROL, {1'b1, rows[i].nine, 5'h18, rows[i].ninth});
      bits(n);
      chk(shift >> (32 - n), exp_w);
    end
    $display("rows done");
    // back to back words, flag and request
    apb(1'b1, IDX_TRANSMIT_STATUS_CONTROL, 8'h90);
    apb(1'b1, IDX_BAUD_DIVISOR, 8'h03);
    apb(1'b1, IDX_PERIPHERAL_IRQ_ENABLES, 8'h10);
    apb(1'b1, IDX_TRANSMIT_STATUS_CONTROL, 8'hb0);
    clear_model();
    apb(1'b1, IDX_TRANSMIT_BUFFER, 8'h5a);
    apb(1'b0, IDX_PERIPHERAL_IRQ_FLAGS, 8'h00);
    chk(rd[4], 1'b1);
    chk(o_tx_irq, 1'b1);
    apb(1'b1, IDX_PERIPHERAL_IRQ_FLAGS, 8'h00);
    apb(1'b0, IDX_TRANSMIT_STATUS_CONTROL, 8'h00);
    chk(rd[1], 1'b0);
    apb(1'b0, IDX_PERIPHERAL_IRQ_FLAGS, 8'h00);
    chk(rd[4], 1'b1);
    apb(1'b1, IDX_TRANSMIT_BUFFER, 8'hc3);
    chk(o_tx_irq, 1'b0);
    bits(16);
    chk(shift[31:16], 16'hc35a);
    repeat (20) @(posedge i_clk_sys);
    apb(1'b0, IDX_TRANSMIT_STATUS_CONTROL, 8'h00);
    chk(rd[1], 1'b1);
    chk(o_tx_irq, 1'b1);
    apb(1'b1, IDX_PERIPHERAL_IRQ_ENABLES, 8'h00);
    chk(o_tx_irq, 1'b0);
    $display("back to back done");
    // aborts by receive enables and by clearing the enable
    clear_model();
    apb(1'b1, IDX_TRANSMIT_BUFFER, 8'h81);
    bits(3);
    // clock enable low freezes the word in flight and the bus
    i_ce <= 1'b0;
    repeat (40) @(posedge i_clk_sys);
    chk(o_pready, 1'b0);
    chk(count, 3);
    i_ce <= 1'b1;
    apb(1'b1, IDX_RECEIVE_STATUS_CONTROL, 8'h90);
    #1;
    chk({o_pins.ck_oe, o_pins.dt_oe}, 2'b10);
    apb(1'b1, IDX_RECEIVE_STATUS_CONTROL, 8'ha0);
    repeat (100) @(posedge i_clk_sys);
    apb(1'b0, IDX_RECEIVE_STATUS_CONTROL, 8'h00);
    chk(rd, 32'h80);
    #1;
    chk(o_pins.dt_oe, 1'b1);
    apb(1'b1, IDX_TRANSMIT_STATUS_CONTROL, 8'h90);
    #1;
    chk({o_pins.ck_oe, o_pins.dt_oe}, 2'b00);
    apb(1'b1, IDX_TRANSMIT_STATUS_CONTROL, 8'h30);
    #1;
    chk({o_pins.ck_oe, o_pins.dt_oe}, 2'b01);
    // word shifted by the far side's own clock
    ext_en <= 1'b1;
    clear_model();
    apb(1'b1, IDX_TRANSMIT_BUFFER, 8'h96);
    ext_run <= 1'b1;
    bits(8);
    ext_run <= 1'b0;
    chk(shift[31:24], 8'h96);
    repeat (20) @(posedge i_clk_sys);
    ext_en <= 1'b0;
    @(posedge i_clk_sys);
    apb(1'b1, IDX_RECEIVE_STATUS_CONTROL, 8'h00);
    #1;
    chk({o_pins.ck_oe, o_pins.dt_oe}, 2'b00);
    $display("aborts done");
    // second reset in mid-run
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    @(posedge i_clk_sys);
    chk(o_pins, 4'h0);
    apb(1'b0, IDX_TRANSMIT_STATUS_CONTROL, 8'h00);
    chk(rd, {24'h0, RST_TRANSMIT_STATUS_CONTROL});
    $display("second reset done");
    close_out();
  end
endmodule
